// >>> verilog/gpplg_pkg.sv
// Constants for the gated port pattern logic block.
// Assumes a 32-bit local bus with single word accesses at the listed offsets.
// Functional notes
// - Read-only firmware revision word at 0x1000.
// - Read of 0x1004 returns port A.
// - Read of 0x1008 returns port B.
// - Read of 0x100c returns driven port C.
// - Status holds ready, gates and clears, bits 0-4.
// - Read/write mask for port A, one masks.
// - Read/write mask for port B, one masks.
// - Control bit 8 selects gate connector level.
// - Control bit 5 ends the register gate.
// - Control bit 4 starts the register gate.
// - Selector 0-3 gives A, B, AND, OR.
// - Selector 4-7 drives captured versions of those.
// - Captured bits set and stay set.
// - Selector 8 drives free-running clock counter.
// - Selector 9 to f drives software register.
// - Read/write user value at 0x180c feeds C.
package gpplg_pkg;
    localparam int          DW            = 32;          // Data width
    localparam int          AW            = 16;          // Local address width
    localparam logic [15:0] OFS_REV       = 16'h1000;    // Firmware revision
    localparam logic [15:0] OFS_A_VAL     = 16'h1004;    // Port A readback
    localparam logic [15:0] OFS_B_VAL     = 16'h1008;    // Port B readback
    localparam logic [15:0] OFS_C_VAL     = 16'h100c;    // Port C readback
    localparam logic [15:0] OFS_STATUS    = 16'h1010;    // Gate status
    localparam logic [15:0] OFS_A_MASK    = 16'h1800;    // Port A mask
    localparam logic [15:0] OFS_B_MASK    = 16'h1804;    // Port B mask
    localparam logic [15:0] OFS_CTRL      = 16'h1808;    // Pattern control
    localparam logic [15:0] OFS_C_USER    = 16'h180c;    // Port C user value
    localparam logic [31:0] FW_REVISION   = 32'h0000_0001; // Arbitrary revision value
    localparam int          CTL_SEL_LSB   = 0;           // Selector field low bit
    localparam int          CTL_SEL_MSB   = 3;           // Selector field high bit
    localparam int          CTL_START     = 4;           // Gate start bit
    localparam int          CTL_STOP      = 5;           // Gate stop bit
    localparam int          CTL_LEVEL     = 8;           // Gate connector level bit
    localparam int          ST_READY      = 0;           // Status: data ready
    localparam int          ST_EXT_GATE   = 1;           // Status: external gate
    localparam int          ST_EXT_CLR    = 2;           // Status: external clear
    localparam int          ST_REG_GATE   = 3;           // Status: register gate
    localparam int          ST_REG_CLR    = 4;           // Status: register clear
    localparam logic [31:0] CTRL_RST      = 32'h0000_0000; // Control reset value
    localparam logic [31:0] ZERO_W        = 32'h0000_0000; // All-zero word
    localparam logic [31:0] CNT_STEP      = 32'h0000_0001; // Counter increment
    localparam logic [3:0]  SEL_A         = 4'h0;        // Port A
    localparam logic [3:0]  SEL_B         = 4'h1;        // Port B
    localparam logic [3:0]  SEL_AND       = 4'h2;        // A AND B
    localparam logic [3:0]  SEL_OR        = 4'h3;        // A OR B
    localparam logic [3:0]  SEL_CAP_A     = 4'h4;        // Captured A
    localparam logic [3:0]  SEL_CAP_B     = 4'h5;        // Captured B
    localparam logic [3:0]  SEL_CAP_AND   = 4'h6;        // Captured AND
    localparam logic [3:0]  SEL_CAP_OR    = 4'h7;        // Captured OR
    localparam logic [3:0]  SEL_COUNT     = 4'h8;        // Clock counter
endpackage : gpplg_pkg

// >>> verilog/gpplg_top.sv
// Gated port pattern logic: masks ports A and B, combines, captures and gates onto C.
// Assumes a single-cycle local bus on mclk; external gate and clear arrive asynchronously.
// Port A and B pins are asynchronous too and pass three flip-flops before use.
`timescale 1ns/1ns
module gpplg_top
(
    // Clock, reset, enable
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     clk_en,
    // Local register bus
    input  wire logic [gpplg_pkg::AW-1:0] bus_addr,
    input  wire logic                     bus_wr,
    input  wire logic                     bus_rd,
    input  wire logic [gpplg_pkg::DW-1:0] bus_wdata,
    output logic      [gpplg_pkg::DW-1:0] bus_rdata,
    output logic                          bus_rvalid,
    // User ports
    input  wire logic [gpplg_pkg::DW-1:0] port_a,
    input  wire logic [gpplg_pkg::DW-1:0] port_b,
    output logic      [gpplg_pkg::DW-1:0] port_c,
    // Gate connectors
    input  wire logic                     gate_connector_0,
    input  wire logic                     gate_connector_1,
    output logic                          gate_level_ttl
);
    import gpplg_pkg::*;

    logic [DW-1:0] mask_a_r;          // Port A mask
    logic [DW-1:0] mask_b_r;          // Port B mask
    logic [DW-1:0] ctrl_r;            // Pattern control
    logic [DW-1:0] user_c_r;          // Port C user value
    logic [DW-1:0] cap_r;             // Sticky capture
    logic [DW-1:0] cnt_r;             // Free-running counter
    logic [DW-1:0] a_s1_r, a_s2_r, a_s3_r;  // Port A synchroniser
    logic [DW-1:0] b_s1_r, b_s2_r, b_s3_r;  // Port B synchroniser
    logic [DW-1:0] a_q_r, b_q_r;      // Agreed input values
    logic [2:0]    g_s_r, c_s_r;      // Gate and clear synchronisers
    logic          ext_gate_r;        // Filtered external gate
    logic          ext_clr_r;         // Filtered external clear
    logic          reg_gate_r;        // Register-driven gate
    logic          reg_clr_r;         // Register-driven clear pulse
    logic          ready_r;           // Data ready flag

    // Decode and selection
    wire [3:0]    sel      = ctrl_r[CTL_SEL_MSB:CTL_SEL_LSB];
    wire          wr_ctrl  = bus_wr && (bus_addr == OFS_CTRL);
    wire          do_start = wr_ctrl && bus_wdata[CTL_START];
    wire          do_stop  = wr_ctrl && bus_wdata[CTL_STOP];
    wire          wr_sel_w = wr_ctrl && (bus_wdata[CTL_SEL_MSB:CTL_SEL_LSB] != sel);
    // A set mask bit forces its channel to zero in every result
    wire [DW-1:0] a_m      = a_q_r & ~mask_a_r;
    wire [DW-1:0] b_m      = b_q_r & ~mask_b_r;
    wire [DW-1:0] a_and_b  = a_m & b_m;
    wire [DW-1:0] a_or_b   = a_m | b_m;
    // Either gate source opens port C; either clear empties the capture
    wire          gate_on  = reg_gate_r | ext_gate_r;
    wire          clr_any  = reg_clr_r | ext_clr_r;
    // Capture source for selector codes 4 to 7
    wire [DW-1:0] cap_src  = (sel == SEL_CAP_A)   ? a_m :
                             (sel == SEL_CAP_B)   ? b_m :
                             (sel == SEL_CAP_AND) ? a_and_b :
                             (sel == SEL_CAP_OR)  ? a_or_b : ZERO_W;
    wire          is_cap   = (sel >= SEL_CAP_A) && (sel <= SEL_CAP_OR);
    // Live result while gated; codes 4 to 7 show the sticky word
    wire [DW-1:0] live_c   = (sel == SEL_A)     ? a_m :
                             (sel == SEL_B)     ? b_m :
                             (sel == SEL_AND)   ? a_and_b :
                             (sel == SEL_OR)    ? a_or_b : cap_r;
    // Counter and user value ignore the gate; other codes idle low
    wire [DW-1:0] c_nxt    = (sel == SEL_COUNT) ? cnt_r :
                             (sel >  SEL_COUNT) ? user_c_r :
                             gate_on            ? live_c : ZERO_W;
    // Status word, one named bit per flag, reserved bits read as zero
    wire [DW-1:0] status_w;                                 // Status readback
    assign status_w[ST_READY]          = ready_r;
    assign status_w[ST_EXT_GATE]       = ext_gate_r;
    assign status_w[ST_EXT_CLR]        = ext_clr_r;
    assign status_w[ST_REG_GATE]       = reg_gate_r;
    assign status_w[ST_REG_CLR]        = reg_clr_r;
    assign status_w[DW-1:ST_REG_CLR+1] = ZERO_W[DW-1:ST_REG_CLR+1];
    // Read multiplexer; unmapped offsets read as zero
    wire [DW-1:0] rd_mux   = (bus_addr == OFS_REV)    ? FW_REVISION :
                             (bus_addr == OFS_A_VAL)  ? a_q_r :
                             (bus_addr == OFS_B_VAL)  ? b_q_r :
                             (bus_addr == OFS_C_VAL)  ? port_c :
                             (bus_addr == OFS_STATUS) ? status_w :
                             (bus_addr == OFS_A_MASK) ? mask_a_r :
                             (bus_addr == OFS_B_MASK) ? mask_b_r :
                             (bus_addr == OFS_CTRL)   ? ctrl_r :
                             (bus_addr == OFS_C_USER) ? user_c_r : ZERO_W;

    // Input synchronisers, three stages each
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            // Clear every stage
            a_s1_r <= ZERO_W;
            a_s2_r <= ZERO_W;
            a_s3_r <= ZERO_W;
            b_s1_r <= ZERO_W;
            b_s2_r <= ZERO_W;
            b_s3_r <= ZERO_W;
            g_s_r  <= 3'h0;
            c_s_r  <= 3'h0;
        end
        else if (clk_en)
        begin
            // Only stage two reads stage one
            a_s1_r <= port_a;
            a_s2_r <= a_s1_r;
            a_s3_r <= a_s2_r;
            b_s1_r <= port_b;
            b_s2_r <= b_s1_r;
            b_s3_r <= b_s2_r;
            g_s_r  <= {g_s_r[1:0], gate_connector_0};
            c_s_r  <= {c_s_r[1:0], gate_connector_1};
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            a_q_r      <= ZERO_W;
            b_q_r      <= ZERO_W;
            ext_gate_r <= 1'b0;
            ext_clr_r  <= 1'b0;
        end
        else if (clk_en)
        begin
            // A bit moves only when stages two and three agree on it
            a_q_r <= (a_s2_r & a_s3_r) | (a_q_r & (a_s2_r ^ a_s3_r));
            b_q_r <= (b_s2_r & b_s3_r) | (b_q_r & (b_s2_r ^ b_s3_r));
            if (g_s_r[1] == g_s_r[2])
                ext_gate_r <= g_s_r[2];
            if (c_s_r[1] == c_s_r[2])
                ext_clr_r <= c_s_r[2];
        end
    end

    // Software registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mask_a_r <= ZERO_W;
            mask_b_r <= ZERO_W;
            ctrl_r   <= CTRL_RST;
            user_c_r <= ZERO_W;
        end
        else if (clk_en && bus_wr)
        begin
            // Writes to read-only or unmapped offsets fall through here
            if (bus_addr == OFS_A_MASK)
                mask_a_r <= bus_wdata;
            if (bus_addr == OFS_B_MASK)
                mask_b_r <= bus_wdata;
            if (wr_ctrl)
                ctrl_r   <= bus_wdata;
            if (bus_addr == OFS_C_USER)
                user_c_r <= bus_wdata;
        end
    end

    // Register gate: start sets, stop ends and wins; selector change clears captures
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            reg_gate_r <= 1'b0;
            reg_clr_r  <= 1'b0;
        end
        else if (clk_en)
        begin
            // Stop wins when start and stop are written together
            if (do_stop)
                reg_gate_r <= 1'b0;
            else if (do_start)
                reg_gate_r <= 1'b1;
            reg_clr_r <= wr_sel_w;
        end
    end

    // Sticky capture while gated; a set in the clear cycle survives
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cap_r   <= ZERO_W;
            ready_r <= 1'b0;
        end
        else if (clk_en)
        begin
            // A capture set wins over a clear in the same cycle
            if (is_cap && gate_on)
                cap_r <= (clr_any ? ZERO_W : cap_r) | cap_src;
            else if (clr_any)
                cap_r <= ZERO_W;
            // Ready follows the same set-wins rule as the capture word
            ready_r <= ((clr_any ? 1'b0 : ready_r) | ((is_cap && gate_on) && (cap_src != ZERO_W)));
        end
    end

    // Counter, output and bus read
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_r          <= ZERO_W;
            port_c         <= ZERO_W;
            bus_rdata      <= ZERO_W;
            bus_rvalid     <= 1'b0;
            gate_level_ttl <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt_r          <= cnt_r + CNT_STEP;
            port_c         <= c_nxt;
            // Read data stands for one cycle and is zero otherwise
            bus_rdata      <= bus_rd ? rd_mux : ZERO_W;
            bus_rvalid     <= bus_rd;
            gate_level_ttl <= ctrl_r[CTL_LEVEL];
        end
    end

    // Checks
    sequence stop_write_s;
        wr_ctrl && bus_wdata[CTL_STOP] && clk_en;
    endsequence

    gate_stop_a: assert property (@(posedge mclk) disable iff (rst)
        stop_write_s |=> !reg_gate_r) else $error("register gate did not end");
    gate_start_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && do_start && !do_stop) |=> reg_gate_r) else $error("register gate did not start");
    user_out_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && sel > SEL_COUNT) |=> port_c == $past(user_c_r)) else $error("user value not on port c");
    idle_low_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && sel < SEL_COUNT && !gate_on) |=> port_c == ZERO_W) else $error("port c not low without gate");
    cap_sticky_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && !clr_any) |=> (cap_r & $past(cap_r)) == $past(cap_r)) else $error("captured bit lost");
    cap_clear_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && clr_any && !(is_cap && gate_on)) |=> cap_r == ZERO_W) else $error("capture not cleared");
    count_run_a: assert property (@(posedge mclk) disable iff (rst)
        clk_en ##1 clk_en |=> cnt_r == $past(cnt_r, 2) + 32'h0000_0002) else $error("counter not free-running");
    level_out_a: assert property (@(posedge mclk) disable iff (rst)
        clk_en |=> gate_level_ttl == $past(ctrl_r[CTL_LEVEL])) else $error("level select not driven");
    rev_read_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && bus_rd && bus_addr == OFS_REV) |=> bus_rvalid && bus_rdata == FW_REVISION)
        else $error("revision read wrong");

    // Read cycle and capture cycle used by the checks below
    sequence read_cycle_s;
        clk_en && bus_rd;
    endsequence

    sequence cap_cycle_s;
        clk_en && is_cap && gate_on;
    endsequence

    // Readback words appear one cycle after the read strobe
    a_read_a: assert property (@(posedge mclk) disable iff (rst)
        read_cycle_s ##0 (bus_addr == OFS_A_VAL) |=> bus_rdata == $past(a_q_r)) else $error("port a readback wrong");
    b_read_a: assert property (@(posedge mclk) disable iff (rst)
        read_cycle_s ##0 (bus_addr == OFS_B_VAL) |=> bus_rdata == $past(b_q_r)) else $error("port b readback wrong");
    c_read_a: assert property (@(posedge mclk) disable iff (rst)
        read_cycle_s ##0 (bus_addr == OFS_C_VAL) |=> bus_rdata == $past(port_c)) else $error("port c readback wrong");
    status_gate_a: assert property (@(posedge mclk) disable iff (rst)
        read_cycle_s ##0 (bus_addr == OFS_STATUS) |=> bus_rdata[ST_REG_GATE] == $past(reg_gate_r)
        && bus_rdata[ST_EXT_GATE] == $past(ext_gate_r)) else $error("status gate bits wrong");
    status_rsvd_a: assert property (@(posedge mclk) disable iff (rst)
        read_cycle_s ##0 (bus_addr == OFS_STATUS) |=> bus_rdata[DW-1:ST_REG_CLR+1] == ZERO_W[DW-1:ST_REG_CLR+1])
        else $error("status reserved bits set");
    user_read_a: assert property (@(posedge mclk) disable iff (rst)
        read_cycle_s ##0 (bus_addr == OFS_C_USER) |=> bus_rdata == $past(user_c_r)) else $error("user value readback wrong");

    // Masked channels and combinations on port C
    mask_a_zero_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && gate_on && sel == SEL_A) |=> (port_c & $past(mask_a_r)) == ZERO_W) else $error("masked a channel set");
    mask_b_zero_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && gate_on && sel == SEL_B) |=> (port_c & $past(mask_b_r)) == ZERO_W) else $error("masked b channel set");
    and_out_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && gate_on && sel == SEL_AND) |=> port_c == $past(a_m & b_m)) else $error("and result wrong");
    or_out_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && gate_on && sel == SEL_OR) |=> port_c == $past(a_m | b_m)) else $error("or result wrong");

    // Capture, counter, clears and gate inputs
    cap_keep_a: assert property (@(posedge mclk) disable iff (rst)
        cap_cycle_s |=> (cap_r & $past(cap_src)) == $past(cap_src)) else $error("captured source bit missing");
    cap_drive_a: assert property (@(posedge mclk) disable iff (rst)
        cap_cycle_s |=> port_c == $past(cap_r)) else $error("captured word not on port c");
    ready_set_a: assert property (@(posedge mclk) disable iff (rst)
        cap_cycle_s ##0 (cap_src != ZERO_W) |=> ready_r) else $error("ready not set by capture");
    count_out_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && sel == SEL_COUNT) |=> port_c == $past(cnt_r)) else $error("counter not on port c");
    clear_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && wr_sel_w) |=> reg_clr_r) else $error("register clear not pulsed");
    ext_clr_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && c_s_r[1] && c_s_r[2]) |=> ext_clr_r) else $error("external clear not taken");
    ext_gate_a: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && g_s_r[1] && g_s_r[2]) |=> ext_gate_r) else $error("external gate not taken");
endmodule : gpplg_top

// >>> bench/gpplg_host_model.sv
// Host-side model of the local register bus feeding the pattern block.
// Assumes one strobe cycle per access and read data one cycle after the read strobe.
`timescale 1ns/1ns
module gpplg_host_model
(
    // Clock
    input  wire logic        mclk,
    // Local register bus
    output logic      [15:0] bus_addr,
    output logic             bus_wr,
    output logic             bus_rd,
    output logic      [31:0] bus_wdata,
    input  wire logic [31:0] bus_rdata,
    input  wire logic        bus_rvalid
);
    // Idle bus at time zero
    initial
    begin
        bus_addr  = 16'h0000;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_wdata = 32'h0000_0000;
    end
    // Single 32-bit word write; data lines toggle once released
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge mclk);
        bus_addr  = a;
        bus_wdata = d;
        bus_wr    = 1'b1;
        @(negedge mclk);
        bus_wr    = 1'b0;
        bus_wdata = ~d;
    endtask : wr
    // Single 32-bit word read; unknown data if no answer came
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(negedge mclk);
        bus_addr = a;
        bus_rd   = 1'b1;
        @(negedge mclk);
        bus_rd   = 1'b0;
        d        = (bus_rvalid === 1'b1) ? bus_rdata : 32'hxxxx_xxxx;
    endtask : rd
endmodule : gpplg_host_model

// >>> bench/gated_port_pattern_logic_bench.sv
// Self-checking bench for the gated port pattern block.
// Assumes the host model drives the bus; inputs change on the falling edge.
`timescale 1ns/1ns
module gated_port_pattern_logic_bench;
    import gpplg_pkg::*;
    typedef struct { logic [3:0] sel; logic [31:0] exp; } gpplg_row_t;
    logic        mclk, rst, clk_en, gate_connector_0, gate_connector_1;  // Drivers
    logic        bus_wr, bus_rd, bus_rvalid, gate_level_ttl;          // Bus and level
    logic [15:0] bus_addr;                                             // Bus address
    logic [31:0] bus_wdata, bus_rdata, port_a, port_b, port_c, rd_v, c1; // Data
    int          err_total, n_tests, cyc;                              // Counters
    gpplg_row_t  rows [10];                                            // Ordinary cases
    // Design and host
    gpplg_top dut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .port_a(port_a), .port_b(port_b), .port_c(port_c), .gate_connector_0(gate_connector_0),
        .gate_connector_1(gate_connector_1), .gate_level_ttl(gate_level_ttl));
    gpplg_host_model host (.mclk(mclk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));
    // Clock, 40 ns period
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Read one register and compare the bits under a mask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffff_ffff);
        host.rd(a, rd_v);
        chk(rd_v & m, exp);
    endtask : rdchk
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle
    // Report and end the run
    task automatic close_out;
        $display("tests=%0d errors=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // Hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            close_out();
        end
    end
    // Main sequence
    initial
    begin
        rst = 1'b1;
        clk_en = 1'b1;
        gate_connector_0 = 1'b0;
        gate_connector_1 = 1'b0;
        port_a = 32'hf0f0_3c3c;
        port_b = 32'h0ff0_5a5a;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        // Masks A=0x000000ff, B=0xff000000: masked A f0f03c00, masked B 00f05a5a
        rows = '{'{4'h0, 32'hf0f0_3c00}, '{4'h1, 32'h00f0_5a5a}, '{4'h2, 32'h00f0_1800},
                 '{4'h3, 32'hf0f0_7e5a}, '{4'h4, 32'hf0f0_3c00}, '{4'h5, 32'h00f0_5a5a},
                 '{4'h6, 32'h00f0_1800}, '{4'h7, 32'hf0f0_7e5a}, '{4'h9, 32'h1234_5678},
                 '{4'hf, 32'h1234_5678}};
        idle(3);
        rst = 1'b0;
        chk(port_c, 32'h0);
        rdchk(OFS_REV, FW_REVISION);
        rdchk(OFS_A_MASK, 32'h0);
        rdchk(OFS_CTRL, 32'h0);
        rdchk(16'h1014, 32'h0);
        host.wr(OFS_A_MASK, 32'h0000_00ff);
        host.wr(OFS_B_MASK, 32'hff00_0000);
        host.wr(OFS_C_USER, 32'h1234_5678);
        rdchk(OFS_A_MASK, 32'h0000_00ff);
        rdchk(OFS_B_MASK, 32'hff00_0000);
        rdchk(OFS_C_USER, 32'h1234_5678);
        rdchk(OFS_A_VAL, port_a);
        rdchk(OFS_B_VAL, port_b);
        foreach (rows[i])
        begin
            host.wr(OFS_CTRL, {27'h0, 1'b1, rows[i].sel});
            idle(10);
            chk(port_c, rows[i].exp);
            rdchk(OFS_C_VAL, rows[i].exp);
        end
        rdchk(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
        host.wr(OFS_CTRL, 32'h0000_0020);
        idle(10);
        chk(port_c, 32'h0);
        gate_connector_0 = 1'b1;
        idle(10);
        chk(port_c, 32'hf0f0_3c00);
        rdchk(OFS_STATUS, 32'h0000_0002, 32'h0000_000a);
        gate_connector_0 = 1'b0;
        port_a = 32'h0001_0000;
        idle(8);
        host.wr(OFS_CTRL, 32'h0000_0014);
        idle(8);
        port_a = 32'h0002_0001;
        idle(8);
        chk(port_c, 32'h0003_0000);
        rdchk(OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        port_a = 32'h0;
        gate_connector_1 = 1'b1;
        idle(8);
        rdchk(OFS_STATUS, 32'h0000_0004, 32'h0000_0005);
        gate_connector_1 = 1'b0;
        idle(8);
        chk(port_c, 32'h0);
        host.wr(OFS_CTRL, 32'h0000_0008);
        idle(4);
        c1 = port_c;
        idle(5);
        chk(port_c - c1, 32'h5);
        host.wr(OFS_CTRL, 32'h0000_0100);
        idle(2);
        chk({31'h0, gate_level_ttl}, 32'h1);
        host.wr(OFS_REV, 32'hffff_ffff);
        rdchk(OFS_REV, FW_REVISION);
        clk_en = 1'b0;
        host.wr(OFS_A_MASK, 32'h0000_0005);
        clk_en = 1'b1;
        rdchk(OFS_A_MASK, 32'h0000_00ff);
        rst = 1'b1;
        idle(1);
        rst = 1'b0;
        rdchk(OFS_CTRL, 32'h0);
        chk({31'h0, gate_level_ttl}, 32'h0);
        close_out();
    end
endmodule : gated_port_pattern_logic_bench
